/* hw/apb_wait_regs.sv */
// APB slave holding the area 3 wait control register and a status word.
`timescale 1ns/1ps
`default_nettype none
module apb_wait_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sdram_timing_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  input wire logic [31:0] status_word,
  output logic [31:0] wait_ctrl
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic err;
  } reg_state_t;

  reg_state_t state_reg;
  reg_state_t state_next;
  logic hit_ctrl;
  logic hit_stat;

  assign hit_ctrl = (paddr == sdram_timing_pkg::WAIT_CTRL_OFFSET);
  assign hit_stat = (paddr == sdram_timing_pkg::STATUS_OFFSET);

  always_comb begin
    state_next = state_reg;
    // Answer is prepared in the setup cycle so that data comes from flip-flops.
    if (psel && !penable) begin
      state_next.err = !(hit_ctrl || (hit_stat && !pwrite));
      state_next.rdata = 32'h00000000;
      if (!pwrite && hit_ctrl) begin
        state_next.rdata = state_reg.ctrl & sdram_timing_pkg::WRITABLE_MASK; // R12
      end else if (!pwrite && hit_stat) begin
        state_next.rdata = status_word;
      end
    end
    if (psel && penable && pwrite && hit_ctrl) begin
      state_next.ctrl = pwdata & sdram_timing_pkg::WRITABLE_MASK; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.ctrl <= sdram_timing_pkg::WAIT_CTRL_RESET; // R1 R6 R7 R9
      state_reg.rdata <= 32'h00000000;
      state_reg.err <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.err;
  assign pready = 1'b1;
  assign wait_ctrl = state_reg.ctrl;

endmodule // apb_wait_regs
`default_nettype wire

/* hw/sdram_timing_core.sv */
// SDRAM command spacing for area 3, steered by the wait control register.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sdram_timing_core (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // APB register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sdram_timing_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Command request from the access sequencer
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_CODE,
  input wire logic [1:0] CMD_BANK,
  output logic CMD_READY,
  // Command issued to the memory
  output logic [3:0] SD_CMD,
  output logic [1:0] SD_BANK,
  output logic RD_DATA_STROBE,
  output logic [1:0] CAS_LATENCY
);

  localparam int NB = sdram_timing_pkg::NUM_BANKS;

  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [2:0] cl_cnt;
    logic strobe;
    logic [1:0] pre_bank_h;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic [31:0] wait_ctrl;
  logic [31:0] status_word;
  logic [1:0] trp_code;
  logic [1:0] trcd_code;
  logic [1:0] cl_code;
  logic [1:0] wgap_code;
  logic [2:0] cl_cycles;
  logic [2:0] trp_val;
  logic [2:0] trcd_val;
  logic [2:0] wgap_val;
  logic [2:0] wrap_val;
  logic fire;
  logic allowed;
  logic allpre_busy;
  logic [NB-1:0] trp_busy;
  logic [NB-1:0] trcd_busy;
  logic [NB-1:0] twr_busy;
  logic [NB-1:0] trp_load;
  logic [NB-1:0] trcd_load;
  logic [NB-1:0] twr_load;
  logic [2:0] trp_ld_val;
  logic act_open_h;

  apb_wait_regs u_regs (
    .clk(MCLK),
    .rst(SYS_RST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .status_word(status_word),
    .wait_ctrl(wait_ctrl)
  );

  // Field decode.
  assign trp_code = wait_ctrl[sdram_timing_pkg::TRP_LSB +: 2]; // R1
  assign trcd_code = wait_ctrl[sdram_timing_pkg::TRCD_LSB +: 2]; // R6
  assign cl_code = wait_ctrl[sdram_timing_pkg::CL_LSB +: 2]; // R7
  assign wgap_code = wait_ctrl[sdram_timing_pkg::WGAP_LSB +: 2]; // R9
  assign trp_val = {1'b0, trp_code};
  assign trcd_val = {1'b0, trcd_code};
  assign wgap_val = {1'b0, wgap_code};
  // Write with auto-precharge: start gap plus completion; at most six, so it fits the counter.
  assign wrap_val = wgap_val + trp_val; // R9 R2
  // The reserved latency code would mean nothing; it is treated as the longest one.
  assign cl_cycles = (cl_code == sdram_timing_pkg::CL_CODE_RESERVED) ?
                     sdram_timing_pkg::CL_MAX_CYCLES : (cl_code + 3'h1); // R7 R8
  assign CAS_LATENCY = cl_code;

  // Which command is allowed now.
  always_comb begin
    allowed = 1'b1;
    case (CMD_CODE)
      sdram_timing_pkg::CMD_ACTIVATE: allowed = !trp_busy[CMD_BANK]; // R2 R3 R9
      sdram_timing_pkg::CMD_READ,
      sdram_timing_pkg::CMD_READ_AP,
      sdram_timing_pkg::CMD_WRITE,
      sdram_timing_pkg::CMD_WRITE_AP: allowed = !trcd_busy[CMD_BANK]; // R6
      sdram_timing_pkg::CMD_PRECHARGE: allowed = !twr_busy[CMD_BANK]; // R10
      sdram_timing_pkg::CMD_PRECHARGE_ALL: allowed = (twr_busy == '0); // R10
      sdram_timing_pkg::CMD_AUTO_REFRESH: allowed = !allpre_busy; // R4
      sdram_timing_pkg::CMD_SELF_REFRESH: allowed = !allpre_busy; // R5
      default: allowed = 1'b1;
    endcase
  end

  assign CMD_READY = allowed;
  assign fire = CMD_VALID && allowed;

  // Counter loads on the issued command.
  always_comb begin
    trp_ld_val = trp_val;
    if (CMD_CODE == sdram_timing_pkg::CMD_WRITE_AP) begin
      trp_ld_val = wrap_val; // R9
    end
  end

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      assign trp_load[b] = fire && (
        ((CMD_BANK == 2'(b)) && ((CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE) ||
                               (CMD_CODE == sdram_timing_pkg::CMD_READ_AP) ||
                               (CMD_CODE == sdram_timing_pkg::CMD_WRITE_AP))) ||
        (CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE_ALL)); // R2 R3
      assign trcd_load[b] = fire && (CMD_BANK == 2'(b)) &&
                            (CMD_CODE == sdram_timing_pkg::CMD_ACTIVATE); // R6
      assign twr_load[b] = fire && (CMD_BANK == 2'(b)) &&
                           (CMD_CODE == sdram_timing_pkg::CMD_WRITE); // R10

      wait_counter u_trp (
        .clk(MCLK),
        .rst(SYS_RST),
        .load(trp_load[b]),
        .load_val(trp_ld_val),
        .busy(trp_busy[b])
      );
      wait_counter u_trcd (
        .clk(MCLK),
        .rst(SYS_RST),
        .load(trcd_load[b]),
        .load_val(trcd_val),
        .busy(trcd_busy[b])
      );
      wait_counter u_twr (
        .clk(MCLK),
        .rst(SYS_RST),
        .load(twr_load[b]),
        .load_val(wgap_val),
        .busy(twr_busy[b])
      );
    end
  endgenerate

  wait_counter u_allpre (
    .clk(MCLK),
    .rst(SYS_RST),
    .load(fire && (CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE_ALL)),
    .load_val(trp_val),
    .busy(allpre_busy)
  ); // R4 R5

  assign status_word = {18'h00000, (state_reg.cl_cnt != 3'h0), allpre_busy,
                        twr_busy, trcd_busy, trp_busy};

  // Issue register and read-data strobe after the CAS latency.
  always_comb begin
    state_next = state_reg;
    state_next.cmd = sdram_timing_pkg::CMD_NOP;
    state_next.strobe = (state_reg.cl_cnt == 3'h1); // R7
    if (state_reg.cl_cnt != 3'h0) begin
      state_next.cl_cnt = state_reg.cl_cnt - 3'h1;
    end
    if (fire) begin
      state_next.cmd = CMD_CODE;
      state_next.bank = CMD_BANK;
      if ((CMD_CODE == sdram_timing_pkg::CMD_READ) ||
          (CMD_CODE == sdram_timing_pkg::CMD_READ_AP)) begin
        state_next.cl_cnt = cl_cycles; // R7
      end
      if (CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE) begin
        state_next.pre_bank_h = CMD_BANK;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign SD_CMD = state_reg.cmd;
  assign SD_BANK = state_reg.bank;
  assign RD_DATA_STROBE = state_reg.strobe;

  // Checks.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  assign act_open_h = !trp_busy[state_reg.pre_bank_h];

  pre_to_act_a: assert property ( // R3
    (fire && CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE && trp_code == 2'h2 &&
     !trp_busy[CMD_BANK]) |=> (!act_open_h)[*2] ##1 act_open_h)
    else $error("activate window after precharge wrong");

  act_gate_a: assert property ( // R2
    (CMD_VALID && CMD_CODE == sdram_timing_pkg::CMD_ACTIVATE && trp_busy[CMD_BANK])
    |-> !CMD_READY)
    else $error("activate accepted during precharge wait");

  // The bank is taken from the trigger cycle at every step, so a later request cannot mask it.
  trcd_wait_a: assert property ( // R6
    (fire && CMD_CODE == sdram_timing_pkg::CMD_ACTIVATE && trcd_code == 2'h3)
    |=> trcd_busy[$past(CMD_BANK)] ##1 trcd_busy[$past(CMD_BANK, 2)]
    ##1 trcd_busy[$past(CMD_BANK, 3)] ##1 !trcd_busy[$past(CMD_BANK, 4)])
    else $error("activate to access wait not three cycles");

  access_gate_a: assert property ( // R6
    (CMD_VALID && trcd_busy[CMD_BANK] &&
     (CMD_CODE inside {sdram_timing_pkg::CMD_READ, sdram_timing_pkg::CMD_READ_AP,
                       sdram_timing_pkg::CMD_WRITE, sdram_timing_pkg::CMD_WRITE_AP}))
    |-> !CMD_READY)
    else $error("access accepted during activate wait");

  refresh_gap_a: assert property ( // R4
    (fire && CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE_ALL && trp_code != 2'h0)
    |=> !(fire && CMD_CODE == sdram_timing_pkg::CMD_AUTO_REFRESH))
    else $error("refresh issued too soon after precharge-all");

  refresh_gate_a: assert property ( // R4 R5
    (CMD_VALID && allpre_busy &&
     ((CMD_CODE == sdram_timing_pkg::CMD_AUTO_REFRESH) ||
      (CMD_CODE == sdram_timing_pkg::CMD_SELF_REFRESH)))
    |-> !CMD_READY)
    else $error("refresh accepted during precharge-all wait");

  allpre_gate_a: assert property ( // R10
    (CMD_VALID && CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE_ALL && twr_busy != '0)
    |-> !CMD_READY)
    else $error("precharge-all accepted during write wait");

  self_gap_a: assert property ( // R5
    (fire && CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE_ALL && trp_code == 2'h1)
    |=> allpre_busy ##1 !allpre_busy)
    else $error("self-refresh gap not one cycle");

  write_pre_a: assert property ( // R10
    (fire && CMD_CODE == sdram_timing_pkg::CMD_WRITE && wgap_code != 2'h0)
    |=> twr_busy[$past(CMD_BANK)] ##[1:3] !twr_busy[$past(CMD_BANK, 2)])
    else $error("write to precharge wait wrong");

  wrap_hold_a: assert property ( // R9
    (fire && CMD_CODE == sdram_timing_pkg::CMD_WRITE_AP && wgap_code == 2'h1 &&
     trp_code == 2'h1) |=> trp_busy[$past(CMD_BANK)][*2])
    else $error("write auto-precharge wait too short");

  // The read shows on the command pins one cycle after acceptance; latency counts from there.
  cas_strobe_a: assert property ( // R7
    (fire && CMD_CODE == sdram_timing_pkg::CMD_READ && cl_code == 2'h1)
    |-> ##2 !RD_DATA_STROBE ##1 RD_DATA_STROBE)
    else $error("read strobe not at latency two");

  cas_one_a: assert property ( // R7
    (fire && CMD_CODE == sdram_timing_pkg::CMD_READ && cl_code == 2'h0)
    |-> ##2 RD_DATA_STROBE)
    else $error("read strobe not at latency one");

  cas_three_a: assert property ( // R7
    (fire && CMD_CODE == sdram_timing_pkg::CMD_READ && cl_code == 2'h2)
    |-> ##4 RD_DATA_STROBE)
    else $error("read strobe not at latency three");

  cmd_issue_a: assert property ( // R13
    fire |=> (SD_CMD == $past(CMD_CODE)) && (SD_BANK == $past(CMD_BANK)))
    else $error("accepted command not issued next cycle");

  cmd_idle_a: assert property ( // R13
    !fire |=> (SD_CMD == sdram_timing_pkg::CMD_NOP))
    else $error("command issued without acceptance");

  reserved_zero_a: assert property ( // R12
    (PSEL && PENABLE && !PWRITE && PADDR == sdram_timing_pkg::WAIT_CTRL_OFFSET)
    |-> ((PRDATA & ~sdram_timing_pkg::WRITABLE_MASK) == 32'h00000000))
    else $error("reserved bits read nonzero");

  trp_field_a: assert property ( // R1
    (state_reg.cmd == sdram_timing_pkg::CMD_PRECHARGE_ALL && trp_code == 2'h0)
    |-> !allpre_busy)
    else $error("zero precharge wait still blocks");

  cover_act_read_c: cover property (
    fire && CMD_CODE == sdram_timing_pkg::CMD_ACTIVATE ##[1:4]
    fire && CMD_CODE == sdram_timing_pkg::CMD_READ);
  cover_allpre_ref_c: cover property (
    fire && CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE_ALL ##[1:4]
    fire && CMD_CODE == sdram_timing_pkg::CMD_AUTO_REFRESH);
  cover_write_pre_c: cover property (
    fire && CMD_CODE == sdram_timing_pkg::CMD_WRITE ##[1:4]
    fire && CMD_CODE == sdram_timing_pkg::CMD_PRECHARGE);
  cover_read_strobe_c: cover property (
    fire && CMD_CODE == sdram_timing_pkg::CMD_READ ##[1:4]
    RD_DATA_STROBE);
  cover_wrap_act_c: cover property (
    fire && CMD_CODE == sdram_timing_pkg::CMD_WRITE_AP ##[1:8]
    fire && CMD_CODE == sdram_timing_pkg::CMD_ACTIVATE);

endmodule // sdram_timing_core
`default_nettype wire

/* hw/sdram_timing_pkg.sv */
// Constants and types for the area 3 SDRAM command timing block.
// How it works
// R1 - Bits 14:13 set 0-3 precharge completion wait cycles; reset 00.
// R2 - Activate to a bank waits the precharge count after its auto-precharge starts.
// R3 - Activate to a bank waits the precharge count after precharge or precharge-all.
// R4 - Auto-refresh waits the precharge count after the preceding precharge-all.
// R5 - Self-refresh entry waits the precharge count after the preceding precharge-all.
// R6 - Bits 11:10 set 0-3 activate to read/write wait cycles; reset 01.
// R7 - Bits 8:7 select CAS latency 1, 2 or 3 cycles; reset 10.
// R8 - Software never writes CAS latency code 11.
// R9 - Bits 4:3, reset 00, add 0-3 cycles after write-autoprecharge before activate.
// R10 - Precharge after a plain write waits the write-to-precharge count.
// R11 - Software sets write-to-precharge count at least the memory's own need.
// R12 - Reserved bits read zero; software writes zero to them.
// R13 - Each constraint is a down-counter loaded on the command, blocking until zero.
package sdram_timing_pkg;

  localparam int NUM_BANKS = 4;
  localparam int CNT_W = 3;
  localparam int ADDR_W = 8;

  localparam logic [7:0] WAIT_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  localparam int TRP_LSB = 13;
  localparam int TRCD_LSB = 10;
  localparam int CL_LSB = 7;
  localparam int WGAP_LSB = 3;

  localparam logic [31:0] WRITABLE_MASK = 32'h00006d98;
  localparam logic [31:0] WAIT_CTRL_RESET = 32'h00000500;
  localparam logic [1:0] CL_CODE_RESERVED = 2'h3;
  localparam logic [2:0] CL_MAX_CYCLES = 3'h3;

  localparam int STAT_TRCD_LSB = 4;
  localparam int STAT_TWR_LSB = 8;
  localparam int STAT_ALLPRE_BIT = 12;
  localparam int STAT_CL_BIT = 13;

  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_READ_AP,
    CMD_WRITE,
    CMD_WRITE_AP,
    CMD_PRECHARGE,
    CMD_PRECHARGE_ALL,
    CMD_AUTO_REFRESH,
    CMD_SELF_REFRESH
  } cmd_t;

endpackage

/* hw/wait_counter.sv */
// Down-counter that holds off a dependent SDRAM command.
`timescale 1ns/1ps
`default_nettype none
module wait_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load request
  input wire logic load,
  input wire logic [sdram_timing_pkg::CNT_W-1:0] load_val,
  // State
  output logic busy
);

  typedef struct packed {
    logic [sdram_timing_pkg::CNT_W-1:0] count;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (state_reg.count != '0) begin
      state_next.count = state_reg.count - 3'h1;
    end
    // A new load never shortens a wait already running.
    if (load && (load_val > state_next.count)) begin
      state_next.count = load_val; // R13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg.count != '0); // R13

endmodule // wait_counter
`default_nettype wire

/* verification/sdram_area3_command_timing_tb.sv */
// Self-checking bench for the area 3 SDRAM command timing block.
`timescale 1ns/1ps
`default_nettype none
module sdram_area3_command_timing_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [1:0] cmd_bank = 2'h0;
  logic cmd_ready;
  logic [3:0] sd_cmd;
  logic [1:0] sd_bank;
  logic rd_strobe;
  logic [1:0] cas_lat;
  logic [15:0] gap;
  logic [15:0] lat;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_checks = 0;

  always #2 mclk = ~mclk;

  sdram_timing_core dut_u (
    .MCLK(mclk), .SYS_RST(sys_rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_BANK(cmd_bank),
    .CMD_READY(cmd_ready), .SD_CMD(sd_cmd), .SD_BANK(sd_bank),
    .RD_DATA_STROBE(rd_strobe), .CAS_LATENCY(cas_lat)
  );

  sdram_model model_u (
    .clk(mclk), .cmd(sd_cmd), .strobe(rd_strobe), .gap(gap), .lat(lat)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the rising edge where ready is seen high.
  // The bus idles one cycle after it so no signal is driven twice at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Holds the request until ready is seen at a rising edge; valid stays up for a follower.
  task automatic issue(input logic [3:0] c, input logic [1:0] b);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_bank <= b;
    @(posedge mclk);
    while (cmd_ready !== 1'b1) begin
      @(posedge mclk);
    end
  endtask

  // Codes: 1 activate, 2 read, 3 read-ap, 4 write, 5 write-ap, 6 precharge, 7 all, 8 ref, 9 self.
  task automatic pair(input logic [3:0] t, input logic [1:0] tb, input logic [3:0] d,
                      input logic [1:0] db, input int n);
    repeat (10) @(posedge mclk);
    issue(t, tb);
    issue(d, db);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'(gap), n + 1, "command spacing");
    chk(32'(sd_bank), 32'(db), "issued bank");
  endtask

  task automatic t_reset;
    apb(1'b0, 8'h00, 32'h00000000);
    chk(rd, 32'h00000500, "reset value");
    chk(32'(cas_lat), 32'h00000002, "latency code");
    $display("test reset done");
  endtask

  task automatic t_regs;
    apb(1'b1, 8'h00, 32'hffffff7f);
    apb(1'b0, 8'h00, 32'h00000000);
    chk(rd, 32'h00006d18, "reserved bits");
    apb(1'b1, 8'h40, 32'h00000001);
    chk({31'h0, err}, 32'h00000001, "unmapped error");
    apb(1'b0, 8'h04, 32'h00000000);
    chk(rd, 32'h00000000, "idle status");
    chk({31'h0, err}, 32'h00000000, "status read error");
    $display("test registers done");
  endtask

  task automatic t_spacing;
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, 8'h00, (n << 13) | (n << 10) | (n << 3) | 32'h00000100);
      pair(4'h6, 2'h1, 4'h1, 2'h1, n);
      pair(4'h7, 2'h0, 4'h1, 2'h2, n);
      pair(4'h3, 2'h0, 4'h1, 2'h0, n);
      pair(4'h7, 2'h0, 4'h8, 2'h0, n);
      pair(4'h7, 2'h0, 4'h9, 2'h0, n);
      pair(4'h1, 2'h3, 4'h2, 2'h3, n);
      pair(4'h1, 2'h3, 4'h5, 2'h3, n);
      pair(4'h5, 2'h2, 4'h1, 2'h2, 2 * n);
      pair(4'h4, 2'h1, 4'h6, 2'h1, n);
      pair(4'h6, 2'h0, 4'h1, 2'h1, 0);
    end
    $display("test spacing done");
  endtask

  task automatic t_latency;
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 8'h00, 32'h00000400 | (c << 7));
      chk(32'(cas_lat), c, "latency code");
      issue(4'h2, 2'h0);
      cmd_valid <= 1'b0;
      repeat (8) @(posedge mclk);
      chk(32'(lat), c + 1, "read latency");
    end
    $display("test latency done");
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_regs();
    t_spacing();
    t_latency();
    give_verdict();
  end

  // The tests need about 700 cycles; this limit is some thirty-five times that.
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule // sdram_area3_command_timing_tb
`default_nettype wire

/* verification/sdram_model.sv */
// Behavioural memory device that measures the spacing of the commands it receives.
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
  // Clock
  input wire logic clk,
  // Command and read strobe from the controller
  input wire logic [3:0] cmd,
  input wire logic strobe,
  // Measured spacing
  output logic [15:0] gap,
  output logic [15:0] lat
);
  logic [15:0] cyc = 16'h0000;
  logic [15:0] last_cmd = 16'h0000;
  logic [15:0] last_rd = 16'h0000;
  always @(posedge clk) begin
    cyc <= cyc + 16'h0001;
    if (cmd != 4'h0) begin
      // A command that comes too early shows up here as a short gap.
      gap <= cyc - last_cmd;
      last_cmd <= cyc;
    end
    if (cmd == 4'h2) begin
      last_rd <= cyc;
    end
    if (strobe) begin
      lat <= cyc - last_rd;
    end
  end
endmodule // sdram_model
`default_nettype wire
